/* hdl/adcf_pkg.sv */
// shared constants and types of the converter frame logic
// assumes a 20 MHz core clock and a host that clocks frames on sclk
package adcf_pkg;

  // timing
  localparam int CORE_CLK_PERIOD_NS = 50; // core clock period
  localparam int CONV_TIME_NS = 500; // conversion duration
  // cycles of one conversion, rounded up
  localparam int CONV_CYCLES =
    (CONV_TIME_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
  localparam int CONV_CNT_W = 13; // width of the conversion counter

  // word layout
  localparam int WORD_BITS = 20; // command and output word width
  localparam int RESULT_BITS = 18; // conversion code width
  localparam int READBACK_LSB = 12; // low end of readback field
  localparam int FULL_PAR_BIT = 1; // full word parity position
  localparam int SPAN_PAR_BIT = 0; // span parity position
  localparam logic [4:0] FULL_COUNT = 5'h14; // capture edges per command
  localparam logic [4:0] LAST_BIT = 5'h13; // index of last output bit

  // command fields
  localparam int OP_MSB = 19; // opcode top bit
  localparam int OP_LSB = 16; // opcode low bit
  localparam int ADDR_MSB = 15; // address top bit
  localparam int ADDR_LSB = 8; // address low bit
  localparam int DATA_MSB = 7; // data top bit
  localparam logic [3:0] OP_READ = 4'h9; // register read prefix
  localparam logic [3:0] OP_WRITE = 4'ha; // register write prefix
  localparam logic [7:0] READ_PAD = 8'h00; // low byte of a read

  // output control register
  localparam logic [7:0] CTRL_ADDR = 8'h11; // its address
  localparam logic [7:0] CTRL_RESET = 8'h00; // its reset value
  localparam int PATN_MSB = 2; // pattern select top bit
  localparam int PARITY_ENABLE_BIT = 3; // parity enable
  localparam int SPAN_MSB = 5; // parity span select top bit
  localparam int SPAN_LSB = 4; // parity span select low bit
  localparam int INTCLK_BIT = 6; // read data on internal clock

  // device functional states
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_ACQUIRE = 2'b01,
    ST_CONVERT = 2'b10
  } adcf_state_t;

endpackage

/* hdl/adcf_serial_frame.sv */
// conversion state control and serial frame logic of an 18-bit converter
// assumes sclk stands still outside frames and while resetn is low,
// and that conv_result is valid on core_clk when a conversion ends
//
// Function
// - ready mirrors conversion status while deselected
// - acquire entered after power-up, reset, conversion
// - reset input moves acquire to reset
// - start rising edge moves acquire to convert
// - internal clock converts; start ignored meanwhile
// - commands are 20 bits: read 1001, write 1010
// - writes on sclk; reads on sclk or internal
// - read command returns register in next frame
// - pattern select top bit sends test pattern
// - otherwise latest conversion result is sent
// - parity off drives low two bits zero
// - parity on appends full and span parity
// - frame spans chip select low; any time
// - select fall: ready low, counters cleared, load
// - capture edge counts and shifts serial input
// - launch edge shifts next output bit out
// - select rise: tri-state, ready later, decode
// - fewer than 20 edges means no operation
// - exactly 20 edges decodes the command
// - more edges keep last 20 bits only
// - short frames still give valid output bits
// - reset state: defaults, ready low, tri-state
// - result is 18-bit two's complement code
module adcf_serial_frame #(
  parameter int CONV_CYCLES = adcf_pkg::CONV_CYCLES, // conversion length
  parameter logic [17:0] TEST_PATTERN = 18'h2aaaa // fixed pattern
) (
  input wire logic core_clk, // core clock
  input wire logic resetn, // synchronous reset, active low
  input wire logic conversion_start, // conversion start pin
  input wire logic cs_n, // chip select pin, active low
  input wire logic sclk, // host serial clock
  input wire logic sdi, // serial input pin
  input wire logic [17:0] conv_result, // code from the converter
  output logic ready_strobe_out, // ready or strobe pin
  output logic conversion_status, // high in acquire, low in reset and convert
  output logic sdo0_out, // serial output on sclk
  output logic sdo0_oe, // drive enable of sdo0
  output logic sdo1_out, // serial output on internal clock
  output logic sdo1_oe // drive enable of sdo1
);

  ////////////////////////////////////////////////////////////////////////
  // elaboration checks

  // the conversion counter must hold the loaded count
  if (CONV_CYCLES < 1 || CONV_CYCLES > 8191) begin : g_bad_conv
    $error("conversion cycle count out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // helper functions

  // parity over a chosen top slice of the data field
  function automatic logic span_parity(input logic [17:0] body,
                                       input logic [1:0] sel);
    logic p;
    p = 1'h0;
    case (sel)
      2'h0: p = ^body[17:10];
      2'h1: p = ^body[17:6];
      2'h2: p = ^body[17:2];
      default: p = ^body;
    endcase
    return p;
  endfunction

  // compose the 20-bit output word of the next frame
  function automatic logic [19:0] build_word(input logic rd_pend,
                                             input logic [7:0] rd_data,
                                             input logic [7:0] ctrl,
                                             input logic [17:0] result);
    logic [17:0] body;
    logic [19:0] w;
    body = result;
    w = 20'h00000;
    if (rd_pend) begin
      w = {rd_data, 12'h000};
    end else begin
      if (ctrl[adcf_pkg::PATN_MSB]) begin
        body = TEST_PATTERN;
      end else begin
        body = result;
      end
      w = {body, 2'h0};
      if (ctrl[adcf_pkg::PARITY_ENABLE_BIT]) begin
        w[adcf_pkg::FULL_PAR_BIT] = ^body;
        w[adcf_pkg::SPAN_PAR_BIT] = span_parity(body,
          ctrl[adcf_pkg::SPAN_MSB:adcf_pkg::SPAN_LSB]);
      end
    end
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // declarations

  adcf_pkg::adcf_state_t state_reg; // functional state
  logic [12:0] conv_cnt_reg; // cycles left in conversion
  logic [17:0] result_reg; // latest conversion code
  logic status_reg; // conversion status, low while converting
  logic link_rst_reg; // clears the capture side during reset
  logic cs_meta_reg; // chip select sync stage one
  logic cs_sync_reg; // chip select sync stage two
  logic cs_prev_reg; // chip select last cycle
  logic cvs_meta_reg; // start sync stage one
  logic cvs_sync_reg; // start sync stage two
  logic cvs_prev_reg; // start last cycle
  logic tog_meta_reg; // frame toggle sync stage one
  logic tog_sync_reg; // frame toggle sync stage two
  logic tog_seen_reg; // last frame toggle handled
  logic [7:0] ctrl_reg; // output control register
  logic rd_pend_reg; // readback owed to the next frame
  logic [7:0] rd_data_reg; // byte for the readback
  logic [19:0] word_reg; // output word held for the next frame
  logic int_active_reg; // internal clock shift running
  logic int_phase_reg; // strobe phase of internal shift
  logic [4:0] int_cnt_reg; // bits sent on internal clock
  logic [19:0] int_sr_reg; // internal clock shift register
  logic ready_reg; // ready pin flop
  logic sdo1_reg; // internal lane data flop
  logic sdo1_oe_reg; // internal lane enable flop
  logic started_reg; // sclk side: frame has seen an edge
  logic sdo0_reg; // sclk side: external lane data
  logic sdo0_oe_reg; // sclk side: external lane enable
  logic [19:0] odr_reg; // output_shift_register
  logic [19:0] idr_reg; // input_shift_register
  logic [4:0] cnt_reg; // capture edge counter, saturating
  logic tog_reg; // flips at each frame's first edge
  logic cs_fall; // chip select fell, core view
  logic cs_rise; // chip select rose, core view
  logic start_rise; // conversion start rose, core view
  logic [3:0] op; // opcode of captured word
  logic [7:0] addr; // address of captured word
  logic [7:0] data; // data of captured word

  assign cs_fall = cs_prev_reg & ~cs_sync_reg;
  assign cs_rise = ~cs_prev_reg & cs_sync_reg;
  assign start_rise = cvs_sync_reg & ~cvs_prev_reg;
  assign op = idr_reg[adcf_pkg::OP_MSB:adcf_pkg::OP_LSB];
  assign addr = idr_reg[adcf_pkg::ADDR_MSB:adcf_pkg::ADDR_LSB];
  assign data = idr_reg[adcf_pkg::DATA_MSB:0];

  ////////////////////////////////////////////////////////////////////////
  // core clock: pin synchronisers

  // two stages before the core clock logic looks at cs_n, conversion_start or the frame toggle
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      cs_meta_reg <= 1'h1;
      cs_sync_reg <= 1'h1;
      cs_prev_reg <= 1'h1;
      cvs_meta_reg <= 1'h0;
      cvs_sync_reg <= 1'h0;
      cvs_prev_reg <= 1'h0;
      tog_meta_reg <= 1'h0;
      tog_sync_reg <= 1'h0;
    end else begin
      cs_meta_reg <= cs_n;
      cs_sync_reg <= cs_meta_reg;
      cs_prev_reg <= cs_sync_reg;
      cvs_meta_reg <= conversion_start;
      cvs_sync_reg <= cvs_meta_reg;
      cvs_prev_reg <= cvs_sync_reg;
      tog_meta_reg <= tog_reg;
      tog_sync_reg <= tog_meta_reg;
    end
  end

  // capture side clear, held during reset while sclk stands still
  always_ff @(posedge core_clk) begin
    link_rst_reg <= ~resetn;
  end

  ////////////////////////////////////////////////////////////////////////
  // core clock: conversion state machine

  // reset, acquire and convert states with the status flag
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_reg <= adcf_pkg::ST_RESET;
      conv_cnt_reg <= 13'h0000;
      status_reg <= 1'h0;
      result_reg <= 18'h00000;
    end else begin
      case (state_reg)
        adcf_pkg::ST_RESET: begin
          // leave reset one cycle after release
          state_reg <= adcf_pkg::ST_ACQUIRE;
          status_reg <= 1'h1;
        end
        adcf_pkg::ST_ACQUIRE: begin
          if (start_rise) begin
            state_reg <= adcf_pkg::ST_CONVERT;
            conv_cnt_reg <= 13'(CONV_CYCLES - 1);
            status_reg <= 1'h0;
          end
        end
        adcf_pkg::ST_CONVERT: begin
          // start edges are not looked at here
          if (conv_cnt_reg == 13'h0000) begin
            state_reg <= adcf_pkg::ST_ACQUIRE;
            status_reg <= 1'h1;
            result_reg <= conv_result;
          end else begin
            conv_cnt_reg <= conv_cnt_reg - 13'h0001;
          end
        end
        default: begin
          state_reg <= adcf_pkg::ST_ACQUIRE;
          status_reg <= 1'h1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // core clock: command processor

  // decode the captured word once the frame has closed
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ctrl_reg <= adcf_pkg::CTRL_RESET;
      rd_pend_reg <= 1'h0;
      rd_data_reg <= 8'h00;
      tog_seen_reg <= 1'h0;
    end else if (cs_fall) begin
      // the readback has been loaded for this frame
      rd_pend_reg <= 1'h0;
    end else if (cs_rise && (tog_sync_reg != tog_seen_reg)) begin
      // a frame without edges leaves the toggle alone
      tog_seen_reg <= tog_sync_reg;
      if (cnt_reg == adcf_pkg::FULL_COUNT) begin
        if (op == adcf_pkg::OP_WRITE) begin
          // register write, taken on the core clock once the frame has closed
          if (addr == adcf_pkg::CTRL_ADDR) begin
            ctrl_reg <= data;
          end
        end else if (op == adcf_pkg::OP_READ &&
                     data == adcf_pkg::READ_PAD) begin
          // read: unknown addresses return zero
          rd_pend_reg <= 1'h1;
          if (addr == adcf_pkg::CTRL_ADDR) begin
            rd_data_reg <= ctrl_reg;
          end else begin
            rd_data_reg <= 8'h00;
          end
        end
        // no-operation and reserved words change nothing
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // core clock: output word

  // word is frozen while chip select is low
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      word_reg <= 20'h00000;
    end else if (cs_sync_reg && cs_prev_reg) begin
      word_reg <= build_word(rd_pend_reg, rd_data_reg, ctrl_reg,
                             result_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // core clock: read data on the internal clock

  // shift the word on sdo1, one bit per two cycles
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      int_active_reg <= 1'h0;
      int_phase_reg <= 1'h0;
      int_cnt_reg <= 5'h00;
      int_sr_reg <= 20'h00000;
      sdo1_reg <= 1'h0;
      sdo1_oe_reg <= 1'h0;
    end else if (cs_sync_reg) begin
      int_active_reg <= 1'h0;
      sdo1_oe_reg <= 1'h0;
    end else if (cs_fall && ctrl_reg[adcf_pkg::INTCLK_BIT]) begin
      int_active_reg <= 1'h1;
      int_phase_reg <= 1'h0;
      int_cnt_reg <= 5'h00;
      int_sr_reg <= word_reg;
      sdo1_oe_reg <= 1'h1;
    end else if (int_active_reg) begin
      int_phase_reg <= ~int_phase_reg;
      if (!int_phase_reg) begin
        // launch while the strobe is low
        sdo1_reg <= int_sr_reg[19];
        int_sr_reg <= {int_sr_reg[18:0], 1'h0};
      end else begin
        if (int_cnt_reg == adcf_pkg::LAST_BIT) begin
          int_active_reg <= 1'h0;
        end
        int_cnt_reg <= int_cnt_reg + 5'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // core clock: ready pin

  // ready follows status, low in frames, strobe for internal reads
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ready_reg <= 1'h0;
    end else if (int_active_reg) begin
      ready_reg <= int_phase_reg;
    end else if (!cs_sync_reg || !cs_prev_reg) begin
      // low in the frame and for one cycle after its end
      ready_reg <= 1'h0;
    end else begin
      ready_reg <= status_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sclk: output shift register and external lane

  // cleared while deselected; first edge loads the frozen word
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      started_reg <= 1'h0;
      sdo0_reg <= 1'h0;
      sdo0_oe_reg <= 1'h0;
      odr_reg <= 20'h00000;
    end else if (!started_reg) begin
      started_reg <= 1'h1;
      sdo0_oe_reg <= ~ctrl_reg[adcf_pkg::INTCLK_BIT];
      sdo0_reg <= word_reg[19];
      odr_reg <= {word_reg[18:0], 1'h0};
    end else begin
      sdo0_reg <= odr_reg[19];
      odr_reg <= {odr_reg[18:0], 1'h0};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sclk: input shift register and capture counter

  // kept after the frame so the core can read it at leisure
  always_ff @(posedge sclk or posedge link_rst_reg) begin
    if (link_rst_reg) begin
      idr_reg <= 20'h00000;
      cnt_reg <= 5'h00;
      tog_reg <= 1'h0;
    end else if (!started_reg) begin
      // first edge: cleared register takes the first bit
      idr_reg <= {19'h00000, sdi};
      cnt_reg <= 5'h01;
      tog_reg <= ~tog_reg;
    end else begin
      idr_reg <= {idr_reg[18:0], sdi};
      if (cnt_reg != adcf_pkg::FULL_COUNT) begin
        cnt_reg <= cnt_reg + 5'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign ready_strobe_out = ready_reg;
  assign conversion_status = status_reg;
  assign sdo0_out = sdo0_reg;
  assign sdo0_oe = sdo0_oe_reg;
  assign sdo1_out = sdo1_reg;
  assign sdo1_oe = sdo1_oe_reg;

endmodule

/* testbench/adcf_serial_frame_asserts.sv */
// concurrent checks of the converter frame logic at its ports
// assumes it is bound into adcf_serial_frame with its conversion length
module adcf_serial_frame_asserts #(
  parameter int CONV_CYCLES = 10 // conversion length in core cycles
) (
  input wire logic core_clk, // core clock
  input wire logic resetn, // synchronous reset, active low
  input wire logic conversion_start, // conversion start pin
  input wire logic cs_n, // chip select, active low
  input wire logic sclk, // host serial clock
  input wire logic sdi, // serial input
  input wire logic [17:0] conv_result, // converter code
  input wire logic ready_strobe_out, // ready pin
  input wire logic conversion_status, // low while converting
  input wire logic sdo0_out, // serial output on sclk
  input wire logic sdo0_oe, // drive enable of sdo0
  input wire logic sdo1_out, // serial output on internal clock
  input wire logic sdo1_oe // drive enable of sdo1
);
  timeunit 1ns;
  timeprecision 1ps;
  int low_cnt; // core cycles seen with status low

  ////////////////////////////////////////////////////////////////////////
  // run length of the low phase of the conversion status
  always_ff @(posedge core_clk) begin
    if (!resetn) low_cnt <= 0;
    else if (!conversion_status) low_cnt <= low_cnt + 1;
    else low_cnt <= 0;
  end

  ////////////////////////////////////////////////////////////////////////
  // steps after reset release and after a start edge
  sequence s_reset_quiet;
    !ready_strobe_out && !conversion_status && !sdo1_oe;
  endsequence
  sequence s_wake;
    conversion_status ##1 ready_strobe_out;
  endsequence
  sequence s_conv_begin;
    ##[1:4] !conversion_status;
  endsequence

  a_reset_exit: assert property (@(posedge core_clk) disable iff (!resetn)
    $rose(resetn) |-> s_reset_quiet ##1 s_wake)
    else $error("reset exit sequence wrong");
  a_start_converts: assert property (@(posedge core_clk) disable iff (!resetn)
    $rose(conversion_start) && conversion_status && ready_strobe_out
    |-> s_conv_begin)
    else $error("start edge did not begin a conversion");
  a_conv_length: assert property (@(posedge core_clk) disable iff (!resetn)
    $rose(conversion_status) && $past(resetn, 2)
    |-> low_cnt == CONV_CYCLES)
    else $error("conversion length wrong");
  a_ready_mirror: assert property (@(posedge core_clk) disable iff (!resetn)
    cs_n [*6] |-> ready_strobe_out == $past(conversion_status))
    else $error("ready does not follow status");
  a_frame_ready_low: assert property (@(posedge core_clk) disable iff (!resetn)
    $fell(cs_n) |-> ##[1:4] !ready_strobe_out)
    else $error("ready not low at frame start");
  a_frame_end_ready: assert property (@(posedge core_clk) disable iff (!resetn)
    $rose(cs_n) && conversion_status |-> ##[1:8] ready_strobe_out)
    else $error("ready not back after frame");
  a_outputs_off: assert property (@(posedge core_clk) disable iff (!resetn)
    cs_n [*4] |-> !sdo0_oe && !sdo1_oe)
    else $error("serial output driven while deselected");
  a_lane_exclusive: assert property (@(negedge sclk) disable iff (!resetn)
    !(sdo0_oe && sdo1_oe))
    else $error("both output lanes driven");
  a_drive_in_frame: assert property (@(negedge sclk) disable iff (!resetn)
    sdo0_oe |-> !cs_n)
    else $error("sdo0 driven outside a frame");
endmodule

bind adcf_serial_frame adcf_serial_frame_asserts #(
  .CONV_CYCLES(CONV_CYCLES)
) u_asserts (.core_clk(core_clk), .resetn(resetn),
  .conversion_start(conversion_start), .cs_n(cs_n), .sclk(sclk),
  .sdi(sdi), .conv_result(conv_result), .ready_strobe_out(ready_strobe_out),
  .conversion_status(conversion_status), .sdo0_out(sdo0_out),
  .sdo0_oe(sdo0_oe), .sdo1_out(sdo1_out), .sdo1_oe(sdo1_oe));

/* testbench/adcf_host_model.sv */
// serial host model: opens frames, clocks sclk at 48 ns, reads sdo0
// assumes the device launches on sclk rising; sampled here on falling
module adcf_host_model (
  output logic cs_n, // chip select to the device
  output logic sclk, // serial clock, still outside frames
  output logic sdi, // serial data to the device
  input wire logic ready_strobe_out, // ready from the device
  input wire logic sdo0_out // serial data from the device
);
  timeunit 1ns;
  timeprecision 1ps;
  logic waited; // ready seen high after the frame

  // idle bus at time zero
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // one frame of n clocks; the last 20 bits sent form the command
  task automatic frame(input logic [19:0] cmd, input int n,
    output logic [19:0] rx);
    logic [39:0] w;
    w = {20'hfffff, cmd};
    rx = 20'h00000;
    cs_n = 1'b0;
    #61;
    for (int k = 0; k < n; k++) begin
      sdi = (n >= 20) ? w[n - 1 - k] : cmd[19 - k];
      #24 sclk = 1'b1;
      #24 sclk = 1'b0;
      if (k < 20) rx[19 - k] = sdo0_out;
    end
    #37 cs_n = 1'b1;
    sdi = ~sdi; // released line must not keep its last value
    waited = 1'b0;
    for (int i = 0; i < 40 && !waited; i++) begin
      #50 waited = ready_strobe_out;
    end
  endtask
endmodule

/* testbench/adcf_serial_frame_tb.sv */
// self-checking bench of the converter frame logic
// assumes the host model drives the serial pins and the bench the rest
module adcf_serial_frame_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CONV = 10; // conversion length in core cycles
  localparam logic [17:0] TP = 18'h2aaaa; // test pattern, arbitrary
  logic core_clk, resetn, conversion_start, cs_n, sclk, sdi;
  logic ready_strobe_out, conversion_status;
  logic sdo0_out, sdo0_oe, sdo1_out, sdo1_oe;
  logic [17:0] conv_result, last_code; // code given and last converted
  logic [19:0] rx, e; // received and expected words
  logic [7:0] ctrl; // output control value written last
  int mismatches, total_checks, cycles;

  adcf_serial_frame #(.CONV_CYCLES(CONV), .TEST_PATTERN(TP)) dut (
    .core_clk(core_clk), .resetn(resetn),
    .conversion_start(conversion_start), .cs_n(cs_n), .sclk(sclk),
    .sdi(sdi), .conv_result(conv_result),
    .ready_strobe_out(ready_strobe_out),
    .conversion_status(conversion_status), .sdo0_out(sdo0_out),
    .sdo0_oe(sdo0_oe), .sdo1_out(sdo1_out), .sdo1_oe(sdo1_oe));
  adcf_host_model host (.cs_n(cs_n), .sclk(sclk), .sdi(sdi),
    .ready_strobe_out(ready_strobe_out), .sdo0_out(sdo0_out));

  ////////////////////////////////////////////////////////////////////////
  // compare helpers and expected output word
  task automatic check_word(input logic [19:0] got, input logic [19:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected word at %0t: %h not %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected flag at %0t: %b not %b", $time, got, exp);
    end
  endtask
  function automatic logic [19:0] expw(input logic [17:0] d,
    input logic [7:0] c);
    logic [19:0] w;
    w = {d, 2'b00};
    if (c[3]) begin
      w[1] = ^w[19:2];
      case (c[5:4])
        2'h0: w[0] = ^w[19:12];
        2'h1: w[0] = ^w[19:8];
        2'h2: w[0] = ^w[19:4];
        default: w[0] = ^w[19:2];
      endcase
    end
    return w;
  endfunction
  task automatic wr(input logic [7:0] v);
    host.frame({4'ha, 8'h11, v}, 20, rx);
    ctrl = v;
  endtask
  task automatic nop_check(input logic [19:0] exp);
    host.frame(20'h00000, 20, rx);
    check_word(rx, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic test_convert(input logic [17:0] code);
    int n;
    @(negedge core_clk);
    conv_result = code;
    conversion_start = 1'b1;
    repeat (5) @(negedge core_clk);
    check_bit(conversion_status, 1'b0);
    check_bit(ready_strobe_out, 1'b0);
    conversion_start = 1'b0;
    @(negedge core_clk);
    conversion_start = 1'b1;
    n = 0;
    while (ready_strobe_out !== 1'b1 && n < 40) begin
      @(negedge core_clk);
      n++;
    end
    check_bit(n < 12, 1'b1);
    conversion_start = 1'b0;
    last_code = code;
    nop_check(expw(code, ctrl));
    $display("conversion test done");
  endtask
  task automatic test_parity;
    logic [7:0] v;
    // one set bit in each span slice, so every span gives its own parity
    test_convert(18'h00445);
    for (int s = 0; s < 4; s++) begin
      v = {2'b00, s[1:0], 4'h8};
      wr(v);
      host.frame({4'h9, 8'h11, 8'h00}, 20, rx);
      check_word(rx, expw(last_code, v));
      nop_check({v, 12'h000});
    end
    wr(8'h00);
    $display("parity and readback test done");
  endtask
  task automatic test_frames;
    wr(8'h0c);
    e = expw(TP, 8'h0c);
    nop_check(e);
    host.frame({4'ha, 8'h11, 8'h00}, 12, rx);
    check_word({rx[19:8], 8'h00}, {e[19:8], 8'h00});
    host.frame(20'h00000, 0, rx);
    host.frame({4'hb, 8'h11, 8'h00}, 20, rx);
    nop_check(e);
    host.frame({4'ha, 8'h11, 8'h00}, 24, rx);
    ctrl = 8'h00;
    nop_check(expw(last_code, 8'h00));
    $display("frame length test done");
  endtask
  // read on the internal clock: sdo1 bits strobed by ready rising
  task automatic test_internal;
    logic [19:0] got;
    logic p;
    int b;
    wr(8'h44);
    got = 20'h00000;
    p = 1'b1;
    b = 0;
    fork
      host.frame({4'ha, 8'h11, 8'h00}, 48, rx);
      repeat (60) begin
        @(negedge core_clk);
        if (ready_strobe_out && !p && b < 20) begin
          if (b == 10) check_bit(sdo1_oe & ~sdo0_oe, 1'b1);
          got[19 - b] = sdo1_out;
          b++;
        end
        p = ready_strobe_out;
      end
    join
    ctrl = 8'h00;
    check_bit(b == 20, 1'b1);
    check_word(got, expw(TP, 8'h44));
    nop_check(expw(last_code, 8'h00));
    $display("internal clock test done");
  endtask
  task automatic test_reset_again;
    wr(8'h04);
    @(negedge core_clk);
    resetn = 1'b0;
    repeat (5) @(negedge core_clk);
    check_bit(ready_strobe_out, 1'b0);
    resetn = 1'b1;
    ctrl = 8'h00;
    repeat (4) @(negedge core_clk);
    check_bit(ready_strobe_out, 1'b1);
    check_bit(sdo0_oe | sdo1_oe, 1'b0);
    test_convert(18'h1ffff);
    $display("second reset test done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  // verdict, clock, hang guard and main sequence
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 8000) begin
      mismatches++;
      $display("unexpected hang at %0t: run too long", $time);
      complete_run;
    end
  end
  initial begin
    resetn = 1'b0;
    conversion_start = 1'b0;
    conv_result = 18'h00000;
    ctrl = 8'h00;
    repeat (5) @(negedge core_clk);
    resetn = 1'b1;
    repeat (4) @(negedge core_clk);
    check_bit(ready_strobe_out, 1'b1);
    check_bit(conversion_status, 1'b1);
    check_bit(sdo0_oe | sdo1_oe, 1'b0);
    test_convert(18'h20000);
    test_parity;
    test_frames;
    test_internal;
    test_reset_again;
    complete_run;
  end
endmodule
